//--- logic/dual_pot_consts.svh
// Constants for the dual potentiometer serial control block
`ifndef DUAL_POT_CONSTS_SVH
`define DUAL_POT_CONSTS_SVH

// ****************************************************************
// Pin positions inside the synchroniser vector
// ****************************************************************
`define SYNC_W 5
`define PIN_SCK 0
`define PIN_CS 1
`define PIN_SI 2
`define PIN_HOLD 3
`define PIN_WP 4
`define SYNC_RST 5'h1A

// ****************************************************************
// Instruction byte layout and operation codes
// ****************************************************************
`define OP_HI 7
`define OP_LO 4
`define DIR_BIT 3
`define POT_BIT 2
`define IDX_HI 2
`define IDX_LO 0
`define OPC_RD_WIPER 4'h9
`define OPC_WR_WIPER 4'hA
`define OPC_RD_SAVED 4'hB
`define OPC_WR_SAVED 4'hC
`define OPC_COPY 4'hD
`define OPC_STEP 4'hE

// ****************************************************************
// Sizes and reset values
// ****************************************************************
`define BIT_ZERO 3'h0
`define BIT_ONE 3'h1
`define BIT_LAST 3'h7
`define SET_ONE 6'h01
`define SET_MIN 6'h00
`define SET_MAX 6'h3F
`define SAVED_RST 6'h20
`define NUM_POTS 2
`define NUM_SAVED 8
`define SAVED_PER_POT 4
`define TAP_ONE 64'h0000_0000_0000_0001
`define TAP_RST 64'h0000_0001_0000_0000
`define BYTE_ZERO 8'h00
`define PAD_ZERO 2'h0

`endif

//--- logic/dual_pot_pkg.sv
// Types shared by the dual potentiometer serial control block
`include "dual_pot_consts.svh"
package dual_pot_pkg;
   typedef logic [5:0] setting_t;
   typedef logic [63:0] tap_t;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_INSTR = 3'b001,
      ST_WR_DATA = 3'b010,
      ST_RD_DATA = 3'b011,
      ST_STEP = 3'b100,
      ST_DONE = 3'b101
   } phase_t;
   typedef enum logic [3:0] {
      OP_RD_WIPER = `OPC_RD_WIPER,
      OP_WR_WIPER = `OPC_WR_WIPER,
      OP_RD_SAVED = `OPC_RD_SAVED,
      OP_WR_SAVED = `OPC_WR_SAVED,
      OP_COPY = `OPC_COPY,
      OP_STEP = `OPC_STEP
   } opcode_t;
endpackage : dual_pot_pkg

//--- logic/pin_sync_if.sv
// Carrier between the pin synchroniser and the serial control logic
`timescale 1ns/10ps
interface pin_sync_if #(parameter int W = 5);
   logic [W-1:0] raw;
   logic [W-1:0] level;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport sync_side (input raw, output level, rise, fall);
   modport user_side (output raw, input level, rise, fall);
endinterface : pin_sync_if

//--- logic/pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module pin_sync #(
   parameter int W = 5,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   pin_sync_if.sync_side sif
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] level_r;
   logic [W-1:0] rise_r;
   logic [W-1:0] fall_r;
   logic [W-1:0] agree;

   // ****************************************************************
   // Metastability chain; only s2_r reads s1_r
   // ****************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         s1_r <= RST_VAL;
         s2_r <= RST_VAL;
         s3_r <= RST_VAL;
      end else begin
         s1_r <= sif.raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // A change counts once stages two and three agree
   assign agree = ~(s2_r ^ s3_r);

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         level_r <= RST_VAL;
         rise_r <= '0;
         fall_r <= '0;
      end else begin
         level_r <= (agree & s3_r) | (~agree & level_r);
         rise_r <= agree & s3_r & ~level_r;
         fall_r <= agree & ~s3_r & level_r;
      end
   end

   assign sif.level = level_r;
   assign sif.rise = rise_r;
   assign sif.fall = fall_r;
endmodule : pin_sync

//--- logic/dual_pot_serial_control.sv
// Serial target logic of a dual 64-tap digital potentiometer
// How it works
// - Paused: serial output released to high impedance
// - Paused: serial input transitions are ignored
// - Bit position and partial byte survive pause
// - Two wiper settings, eight saved settings
// - Exactly one tap per pot on wiper
// - Controller reads and writes all settings
// - Copy between wiper and own saved settings
// - Step mode increments or decrements wiper
// - Instruction captured in eight-bit register
// - Chip select fall starts; first byte instruction
// - Serial input sampled on clock rising edge
// - Six operation codes select the operation
// - Reset loads first saved setting into wiper
// - Chip select rise commits valid saved write
// - Write protect low blocks saved-setting writes
// - Serial output changes on clock falling edge
`timescale 1ns/10ps
module dual_pot_serial_control
   import dual_pot_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic nrst_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic si_in,
   input wire logic hold_n_in,
   input wire logic wp_n_in,
   output logic so_out,
   output logic so_oe_n_out,
   output setting_t [1:0] wiper_setting_out,
   output tap_t [1:0] tap_sel_out
);
   pin_sync_if #(.W(`SYNC_W)) sif ();

   setting_t wiper_setting_reg [`NUM_POTS];
   setting_t saved_setting_reg [`NUM_SAVED];
   phase_t phase_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_in_r;
   logic [7:0] instr_r;
   logic [7:0] shift_out_r;
   logic so_r;
   logic so_drive_r;
   logic paused_r;
   logic boot_done_r;
   logic nv_pend_r;
   logic [2:0] nv_addr_r;
   setting_t nv_data_r;
   tap_t tap_r [`NUM_POTS];

   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic cs_low;
   logic si;
   logic wp_ok;
   logic [7:0] byte_nxt;
   logic [7:0] cmd;
   logic byte_done;
   logic instr_done;
   logic data_done;
   logic step_ev;
   opcode_t op;
   logic pot;
   logic [2:0] sidx;
   setting_t cur_wiper;

   // ****************************************************************
   // Pin synchronisation and edge events
   // ****************************************************************
   assign sif.raw = {wp_n_in, hold_n_in, si_in, cs_n_in, sck_in};

   pin_sync #(.W(`SYNC_W), .RST_VAL(`SYNC_RST)) u_sync (
      .ref_clk_in(ref_clk_in),
      .nrst_in(nrst_in),
      .sif(sif)
   );

   assign cs_low = ~sif.level[`PIN_CS];
   assign cs_fall = sif.fall[`PIN_CS];
   assign cs_rise = sif.rise[`PIN_CS];
   assign si = sif.level[`PIN_SI];
   assign wp_ok = sif.level[`PIN_WP];
   // Clock edges are dropped while paused
   assign sck_rise = sif.rise[`PIN_SCK] & cs_low & ~paused_r;
   assign sck_fall = sif.fall[`PIN_SCK] & cs_low & ~paused_r;

   // Pause state follows the hold pin only while the clock is low
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         paused_r <= 1'b0;
      end else if (!cs_low) begin
         paused_r <= 1'b0;
      end else if (!sif.level[`PIN_SCK]) begin
         paused_r <= ~sif.level[`PIN_HOLD];
      end
   end

   // ****************************************************************
   // Decode of the instruction in flight
   // ****************************************************************
   assign byte_nxt = {shift_in_r[6:0], si};
   assign byte_done = sck_rise && bit_cnt_r == `BIT_LAST
      && (phase_r == ST_INSTR || phase_r == ST_WR_DATA);
   assign instr_done = byte_done && phase_r == ST_INSTR;
   assign data_done = byte_done && phase_r == ST_WR_DATA;
   assign step_ev = sck_rise && phase_r == ST_STEP;
   assign cmd = (phase_r == ST_INSTR) ? byte_nxt : instr_r;
   assign op = opcode_t'(cmd[`OP_HI:`OP_LO]);
   assign pot = cmd[`POT_BIT];
   assign sidx = cmd[`IDX_HI:`IDX_LO];
   assign cur_wiper = wiper_setting_reg[pot];

   // ****************************************************************
   // Transfer sequencer
   // ****************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         phase_r <= ST_IDLE;
         bit_cnt_r <= `BIT_ZERO;
         shift_in_r <= `BYTE_ZERO;
         instr_r <= `BYTE_ZERO;
      end else if (!cs_low) begin
         phase_r <= ST_IDLE;
      end else if (cs_fall) begin
         phase_r <= ST_INSTR;
         bit_cnt_r <= `BIT_ZERO;
      end else if (sck_rise) begin
         // Counter and partial byte hold still while paused
         shift_in_r <= byte_nxt;
         bit_cnt_r <= bit_cnt_r + `BIT_ONE;
         if (instr_done) begin
            instr_r <= byte_nxt;
            unique case (op)
               OP_RD_WIPER, OP_RD_SAVED: phase_r <= ST_RD_DATA;
               OP_WR_WIPER, OP_WR_SAVED: phase_r <= ST_WR_DATA;
               OP_STEP: phase_r <= ST_STEP;
               OP_COPY: phase_r <= ST_DONE;
               default: phase_r <= ST_DONE;
            endcase
         end else if (data_done) begin
            phase_r <= ST_DONE;
         end
      end
   end

   // ****************************************************************
   // Wiper settings
   // ****************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         boot_done_r <= 1'b0;
         for (int p = 0; p < `NUM_POTS; p++) begin
            wiper_setting_reg[p] <= `SET_MIN;
         end
      end else if (!boot_done_r) begin
         boot_done_r <= 1'b1;
         for (int p = 0; p < `NUM_POTS; p++) begin
            wiper_setting_reg[p] <= saved_setting_reg[p * `SAVED_PER_POT];
         end
      end else if (instr_done && op == OP_COPY && !cmd[`DIR_BIT]) begin
         wiper_setting_reg[pot] <= saved_setting_reg[sidx];
      end else if (data_done && op == OP_WR_WIPER) begin
         // Wiper writes ignore write protect
         wiper_setting_reg[pot] <= byte_nxt[5:0];
      end else if (step_ev) begin
         // Saturates at both ends instead of wrapping
         if (si && cur_wiper != `SET_MAX) begin
            wiper_setting_reg[pot] <= cur_wiper + `SET_ONE;
         end else if (!si && cur_wiper != `SET_MIN) begin
            wiper_setting_reg[pot] <= cur_wiper - `SET_ONE;
         end
      end
   end

   // ****************************************************************
   // Saved settings and the deferred write
   // ****************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         nv_pend_r <= 1'b0;
         nv_addr_r <= `BIT_ZERO;
         nv_data_r <= `SET_MIN;
      end else if (cs_rise || !wp_ok) begin
         // Protect going low mid-transfer cancels the write
         nv_pend_r <= 1'b0;
      end else if (data_done && op == OP_WR_SAVED) begin
         nv_pend_r <= 1'b1;
         nv_addr_r <= sidx;
         nv_data_r <= byte_nxt[5:0];
      end else if (instr_done && op == OP_COPY && cmd[`DIR_BIT]) begin
         nv_pend_r <= 1'b1;
         nv_addr_r <= sidx;
         nv_data_r <= cur_wiper;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < `NUM_SAVED; i++) begin
            saved_setting_reg[i] <= `SAVED_RST;
         end
      end else if (cs_rise && nv_pend_r && wp_ok) begin
         saved_setting_reg[nv_addr_r] <= nv_data_r;
      end
   end

   // ****************************************************************
   // Read data path
   // ****************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         shift_out_r <= `BYTE_ZERO;
         so_r <= 1'b0;
         so_drive_r <= 1'b0;
      end else if (!cs_low) begin
         so_drive_r <= 1'b0;
      end else if (instr_done) begin
         shift_out_r <= (op == OP_RD_SAVED) ?
            {`PAD_ZERO, saved_setting_reg[sidx]} :
            {`PAD_ZERO, cur_wiper};
      end else if (sck_fall && phase_r == ST_RD_DATA) begin
         so_r <= shift_out_r[7];
         shift_out_r <= {shift_out_r[6:0], 1'b0};
         so_drive_r <= 1'b1;
      end
   end

   assign so_out = so_r;
   assign so_oe_n_out = ~(so_drive_r & cs_low & ~paused_r);

   // ****************************************************************
   // Tap decode; one tap per pot, code zero at the low end
   // ****************************************************************
   always_ff @(posedge ref_clk_in) begin
      if (!nrst_in) begin
         for (int p = 0; p < `NUM_POTS; p++) begin
            tap_r[p] <= `TAP_ONE;
         end
      end else begin
         for (int p = 0; p < `NUM_POTS; p++) begin
            tap_r[p] <= `TAP_ONE << wiper_setting_reg[p];
         end
      end
   end

   always_comb begin
      for (int p = 0; p < `NUM_POTS; p++) begin
         wiper_setting_out[p] = wiper_setting_reg[p];
         tap_sel_out[p] = tap_r[p];
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!nrst_in);

   property p_pause_hiz;
      paused_r |-> so_oe_n_out;
   endproperty
   a_pause_hiz: assert property (p_pause_hiz)
      else $error("serial output driven while paused");

   property p_pause_keep;
      paused_r && phase_r != ST_IDLE |=> $stable(bit_cnt_r)
         && $stable(shift_in_r) && $stable(instr_r);
   endproperty
   a_pause_keep: assert property (p_pause_keep)
      else $error("transfer state moved while paused");

   property p_cs_start;
      cs_low && cs_fall |=> phase_r == ST_INSTR && bit_cnt_r == `BIT_ZERO;
   endproperty
   a_cs_start: assert property (p_cs_start)
      else $error("chip select fall did not start a transfer");

   property p_instr_cap;
      instr_done |=> instr_r == $past(byte_nxt);
   endproperty
   a_instr_cap: assert property (p_instr_cap)
      else $error("instruction byte not captured");

   property p_sample;
      sck_rise && !cs_fall |=> shift_in_r[0] == $past(si);
   endproperty
   a_sample: assert property (p_sample)
      else $error("input bit not sampled on clock rise");

   property p_so_fall;
      !$stable(so_out) |-> $past(sck_fall);
   endproperty
   a_so_fall: assert property (p_so_fall)
      else $error("serial output changed off a falling edge");

   property p_boot;
      !boot_done_r |=> wiper_setting_reg[1] ==
         $past(saved_setting_reg[`SAVED_PER_POT]);
   endproperty
   a_boot: assert property (p_boot)
      else $error("first saved setting not loaded at start");

   property p_wp_block;
      !wp_ok ##1 !wp_ok |-> $stable(saved_setting_reg[0]);
   endproperty
   a_wp_block: assert property (p_wp_block)
      else $error("saved setting changed under write protect");

   property p_commit;
      cs_rise && nv_pend_r && wp_ok |=>
         saved_setting_reg[$past(nv_addr_r)] == $past(nv_data_r);
   endproperty
   a_commit: assert property (p_commit)
      else $error("pending saved write not committed");

   property p_step_up;
      boot_done_r && step_ev && si && cur_wiper != `SET_MAX |=>
         wiper_setting_reg[$past(pot)] == $past(cur_wiper) + `SET_ONE;
   endproperty
   a_step_up: assert property (p_step_up)
      else $error("step mode did not increment");

   property p_tap;
      ##1 tap_sel_out[0] == (`TAP_ONE << $past(wiper_setting_reg[0]));
   endproperty
   a_tap: assert property (p_tap)
      else $error("tap select does not match wiper setting");
endmodule : dual_pot_serial_control

//--- dv/spi_ctrl_model.sv
// Behavioural SPI bus controller facing the potentiometer target
`timescale 1ns/10ps
module spi_ctrl_model (
   input wire logic so_in,
   input wire logic so_oe_n_in,
   output logic sck_out,
   output logic cs_n_out,
   output logic si_out,
   output logic hold_n_out
);
   logic [7:0] rd_byte;
   logic rd_evt;
   logic pause_oe_n;
   // Clock parked low outside frames, pause released
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      si_out = 1'b0;
      hold_n_out = 1'b1;
      rd_evt = 1'b0;
      rd_byte = 8'h00;
      pause_oe_n = 1'b1;
   end
   // Pause with the clock low; data and clock wiggle, none may count
   task automatic pause(input logic b);
      int k;
      hold_n_out = 1'b0;
      pause_oe_n = 1'b1;
      for (k = 0; k < 6; k++) begin
         #25 si_out = ~si_out;
         // Even number of clock toggles, so the clock ends low again
         if (k > 1) begin
            sck_out = ~sck_out;
            pause_oe_n = pause_oe_n & so_oe_n_in;
         end
      end
      si_out = b;
      #20 hold_n_out = 1'b1;
      #30;
   endtask : pause
   // Bits placed while clock low; reply sampled late in the high half
   task automatic xfer(input logic [7:0] ins, input logic [7:0] dat,
         input int nd, input int hold_at, input logic rd);
      int i;
      logic b;
      logic [7:0] sh;
      sh = 8'h00;
      cs_n_out = 1'b0;
      #40;
      for (i = 0; i < 8 + nd; i++) begin
         b = (i < 8) ? ins[7 - i] : dat[7 - ((i - 8) % 8)];
         si_out = b;
         #16;
         if (i == hold_at) begin
            pause(b);
         end
         #16 sck_out = 1'b1;
         #31 if (i >= 8) sh = {sh[6:0], so_in};
         #1 sck_out = 1'b0;
      end
      #40 cs_n_out = 1'b1;
      #100;
      if (rd) begin
         rd_byte = sh;
         rd_evt = ~rd_evt;
      end
   endtask : xfer
endmodule : spi_ctrl_model

//--- dv/testbench.sv
// Self-checking bench for the dual potentiometer serial control
`timescale 1ns/10ps
module testbench;
   import dual_pot_pkg::*;
   logic ref_clk_in;
   logic nrst_in;
   logic wp_n_in;
   logic sck, cs_n, si, hold_n, so, so_oe_n, so_line, so_last;
   setting_t [1:0] wiper;
   tap_t [1:0] taps;
   setting_t wm [2];
   setting_t sm [8];
   logic [7:0] exp_q [$];
   int fail_count;
   int n_compared;
   int cycles;
   int k;
   setting_t v;
   // *****************************
   // Clock, wire level, instances
   // *****************************
   initial begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   // Released output shows a changing pattern, not the last bit
   assign so_line = so_oe_n ? ~so_last : so;
   always @(posedge ref_clk_in) so_last <= so_line;
   dual_pot_serial_control dual_pot_serial_control_i (
      .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .sck_in(sck),
      .cs_n_in(cs_n), .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n_in),
      .so_out(so), .so_oe_n_out(so_oe_n), .wiper_setting_out(wiper),
      .tap_sel_out(taps));
   spi_ctrl_model spi_ctrl_model_i (
      .so_in(so_line), .so_oe_n_in(so_oe_n), .sck_out(sck),
      .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n));
   // *****************************
   // Checking helpers
   // *****************************
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : finish_test
   task automatic chk(input logic [63:0] got, input logic [63:0] exp,
         input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic pots;
      int p;
      for (p = 0; p < 2; p++) begin
         chk({58'h0, wiper[p]}, {58'h0, wm[p]}, "wiper");
         chk(taps[p], 64'h0000_0000_0000_0001 << wm[p], "tap");
      end
   endtask : pots
   task automatic wr_w(input int p, input setting_t d, input int h);
      spi_ctrl_model_i.xfer({4'hA, 1'b0, p[0], 2'b00}, {2'b00, d}, 8, h, 1'b0);
      wm[p] = d;
      pots();
   endtask : wr_w
   task automatic rd(input logic [7:0] ins, input setting_t e, input int h);
      exp_q.push_back({2'b00, e});
      spi_ctrl_model_i.xfer(ins, 8'h00, 8, h, 1'b1);
   endtask : rd
   task automatic op(input logic [7:0] ins, input logic [7:0] d, input int n);
      spi_ctrl_model_i.xfer(ins, d, n, -1, 1'b0);
   endtask : op
   // Read results come off the oldest note in order
   always @(spi_ctrl_model_i.rd_evt) begin
      if (exp_q.size() > 0) begin
         chk({56'h0, spi_ctrl_model_i.rd_byte},
             {56'h0, exp_q.pop_front()}, "read byte");
      end
   end
   // Hang guard, well above the expected run length
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         finish_test();
      end
   end
   // *****************************
   // Main sequence
   // *****************************
   initial begin
      void'($urandom(32'ha116_a951));
      nrst_in <= 1'b0;
      wp_n_in <= 1'b1;
      fail_count = 0;
      n_compared = 0;
      cycles = 0;
      wm = '{6'h20, 6'h20};
      foreach (sm[i]) sm[i] = 6'h20;
      repeat (8) @(posedge ref_clk_in);
      nrst_in <= 1'b1;
      repeat (12) @(posedge ref_clk_in);
      pots();
      for (k = 0; k < 8; k++) begin
         v = (k < 2) ? 6'h00 : (k < 4) ? 6'h3F : setting_t'($urandom);
         wr_w(k % 2, v, (k == 5) ? 3 : -1);
         rd({4'h9, 1'b0, k[0], 2'b00}, v, (k > 5) ? 11 : -1);
      end
      chk({63'h0, spi_ctrl_model_i.pause_oe_n}, 64'h1, "pause");
      for (k = 0; k < 8; k++) begin
         sm[k] = setting_t'($urandom);
         op({4'hC, 1'b0, k[2:0]}, {2'b00, sm[k]}, 8);
         rd({4'hB, 1'b0, k[2:0]}, sm[k], -1);
      end
      // Protected: saved writes and copies dropped, wiper still moves
      @(posedge ref_clk_in) wp_n_in <= 1'b0;
      for (k = 0; k < 2; k++) begin
         op({4'hC, 1'b0, k[0], 2'b00}, {2'b00, ~sm[k * 4]}, 8);
         op({4'hD, 1'b1, k[0], 2'b01}, 8'h00, 0);
         rd({4'hB, 1'b0, k[0], 2'b00}, sm[k * 4], -1);
         rd({4'hB, 1'b0, k[0], 2'b01}, sm[k * 4 + 1], -1);
         wr_w(k, ~wm[k], -1);
      end
      @(posedge ref_clk_in) wp_n_in <= 1'b1;
      for (k = 0; k < 2; k++) begin
         wr_w(k, setting_t'($urandom), -1);
         op({4'hD, 1'b1, k[0], 2'b10}, 8'h00, 0);
         sm[k * 4 + 2] = wm[k];
         rd({4'hB, 1'b0, k[0], 2'b10}, sm[k * 4 + 2], -1);
         wr_w(k, ~wm[k], -1);
         op({4'hD, 1'b0, k[0], 2'b10}, 8'h00, 0);
         wm[k] = sm[k * 4 + 2];
         pots();
         wr_w(k, 6'h3D, -1);
         op({4'hE, 1'b0, k[0], 2'b00}, 8'hF0, 8);
         wm[k] = 6'h3B;
         pots();
         wr_w(k, 6'h02, -1);
         op({4'hE, 1'b0, k[0], 2'b00}, 8'h01, 8);
         wm[k] = 6'h01;
         pots();
      end
      op(8'h50, 8'h2A, 8);
      op(8'hF4, 8'h15, 8);
      pots();
      finish_test();
   end
endmodule : testbench
